// ==== design/temp_filter.sv ====
`timescale 1ns/1ps
module temp_filter #(
   parameter int W = 11
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  load_i,
   input  wire temp_alarm_pkg::filt_e level_i,
   input  wire logic [W-1:0]          din_i,
   output logic      [W-1:0]          dout_o
);
   logic signed [W+1:0] diff;
   logic signed [W+1:0] step;

   always_comb begin
      diff = $signed({2'h0, din_i}) - $signed({2'h0, dout_o});
      case (level_i)
         temp_alarm_pkg::FILT_L1: step = diff >>> 1;
         temp_alarm_pkg::FILT_L2: step = diff >>> 2;
         default:                 step = diff;
      endcase
   end

   // first-order smoothing; unknown level codes pass data straight
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dout_o <= '0;
      end else if (load_i) begin
         dout_o <= W'($signed({2'h0, dout_o}) + step);
      end
   end
endmodule : temp_filter

// ==== design/temp_limit_alarm.sv ====
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
// Behaviour
// - critical output independent, never masked
// - critical asserts after consecutive over-limit readings
// - critical holds until all below limit-hysteresis
// - critical status follows output, self clearing
// - open-drain active-low alert, mode selectable
// - interrupt mode: high, low, fault alert
// - interrupt alert holds until status cleared
// - global mask deasserts interrupt alert, status updates
// - comparator alert with hysteresis release
// - comparator high status self clearing
// - comparator ignores global mask, honours channel masks
// - beta compensation on first external only
// - six-bit ideality setting per external channel
// - fault check each external channel, each conversion
// - fault zeroes data, skips low check
// - shorted diode reads zero, trips low
// - cathode ground short raises nothing
// - separate consecutive counters for both outputs
// - first external channel digital filter
// - standby updates nothing, checks nothing
module temp_limit_alarm #(
   parameter int NCH = 4
) (
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire logic [7:0]              wb_adr_i,
   input  wire logic [31:0]             wb_dat_i,
   input  wire logic                    wb_we_i,
   input  wire logic [3:0]              wb_sel_i,
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   output logic      [31:0]             wb_dat_o,
   output logic                         wb_ack_o,
   input  wire logic                    conv_done_i,
   input  wire logic [NCH*11-1:0]       raw_temp_i,
   input  wire logic [NCH-1:0]          diode_fault_i,
   output logic                         alert_o,
   output logic                         alert_oe_o,
   output logic                         therm_n_o,
   output logic                         beta_comp_en_o,
   output logic      [(NCH-1)*6-1:0]    ideality_o
);
   localparam int TW  = temp_alarm_pkg::TW;
   localparam int LW  = temp_alarm_pkg::LW;
   localparam int CW  = temp_alarm_pkg::CW;
   localparam int IDW = temp_alarm_pkg::IDW;
   logic [7:0]      cfg;
   logic [7:0]      consec;
   logic [7:0]      hyst;
   logic [NCH-1:0]  chmask;
   logic [LW-1:0]   hi_lim [NCH];
   logic [LW-1:0]   lo_lim [NCH];
   logic [LW-1:0]   cr_lim [NCH];
   logic [TW-1:0]   raw_q  [NCH];
   logic [TW-1:0]   temp   [NCH];
   logic [CW-1:0]   acnt   [NCH];
   logic [CW-1:0]   ccnt   [NCH];
   logic [NCH-1:0]  flt_q;
   logic            eval;
   logic [NCH-1:0]  st_hi;
   logic [NCH-1:0]  st_lo;
   logic [NCH-1:0]  st_flt;
   logic [NCH-1:0]  cmp_st;
   logic [NCH-1:0]  crit_st;
   logic [TW-1:0]   filt_y;
   logic [TW-1:0]   data     [NCH];
   logic [CW-1:0]   next_acnt[NCH];
   logic [CW-1:0]   next_ccnt[NCH];
   logic [NCH-1:0]  v_hi;
   logic [NCH-1:0]  v_lo;
   logic [NCH-1:0]  viol_a;
   logic [NCH-1:0]  viol_c;
   logic [NCH-1:0]  hit_a;
   logic [NCH-1:0]  hit_c;
   logic [NCH-1:0]  act_a;
   logic [NCH-1:0]  below_h;
   logic [NCH-1:0]  below_c;
   logic [CW-1:0]   lim_a;
   logic [CW-1:0]   lim_c;
   logic            comp;
   logic            conv_take;
   logic            req;
   logic            wr_fire;
   logic [31:0]     clr_w;
   logic [31:0]     stat_word;
   logic [31:0]     rd_val;
   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{sel[i]}};
      end
      return m;
   endfunction : lane_mask
   function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d, input logic [3:0] sel);
      return sel[0] ? d[7:0] : old;
   endfunction : merge8
   function automatic logic [7:0] ch_adr(input logic [7:0] base, input int c);
      return 8'(int'(base) + c * temp_alarm_pkg::CH_STRIDE);
   endfunction : ch_adr
   // zero in the count field still means a single reading
   function automatic logic [CW-1:0] cnt_lim(input logic [CW-1:0] f);
      return (f == '0) ? CW'(1) : f;
   endfunction : cnt_lim
   function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] n, input logic [CW-1:0] lim);
      return (n >= lim) ? lim : CW'(n + CW'(1));
   endfunction : sat_inc
   // limit minus hysteresis, floored so a small limit cannot wrap
   function automatic logic [LW-1:0] floor_sub(input logic [LW-1:0] a, input logic [LW-1:0] b);
      return (a > b) ? LW'(a - b) : '0;
   endfunction : floor_sub
   assign comp      = cfg[temp_alarm_pkg::CFG_COMP];
   assign req       = wb_cyc_i & wb_stb_i;
   assign wr_fire   = req & wb_we_i & wb_ack_o;
   assign clr_w     = (wr_fire && wb_adr_i == temp_alarm_pkg::OFS_STATUS) ? (wb_dat_i & lane_mask(wb_sel_i)) : '0;
   assign lim_a     = cnt_lim(consec[temp_alarm_pkg::CON_ALERT +: CW]);
   assign lim_c     = cnt_lim(consec[temp_alarm_pkg::CON_CRIT +: CW]);
   assign conv_take = conv_done_i & cfg[temp_alarm_pkg::CFG_RUN];
   // bus handshake: ack one cycle after request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
         if (req && !wb_ack_o) begin
            wb_dat_o <= rd_val;
         end
      end
   end

   always_comb begin
      stat_word = '0;
      stat_word[temp_alarm_pkg::STAT_HI +: NCH]   = comp ? cmp_st : st_hi;
      stat_word[temp_alarm_pkg::STAT_LO +: NCH]   = st_lo;
      stat_word[temp_alarm_pkg::STAT_FLT +: NCH]  = st_flt;
      stat_word[temp_alarm_pkg::STAT_CRIT +: NCH] = crit_st;
      rd_val = '0;
      case (wb_adr_i)
         temp_alarm_pkg::OFS_CFG:    rd_val[7:0] = cfg;
         temp_alarm_pkg::OFS_CONSEC: rd_val[7:0] = consec;
         temp_alarm_pkg::OFS_HYST:   rd_val[7:0] = hyst;
         temp_alarm_pkg::OFS_CHMASK: rd_val[NCH-1:0] = chmask;
         temp_alarm_pkg::OFS_STATUS: rd_val = stat_word;
         default: rd_val = '0;
      endcase
      for (int c = 0; c < NCH; c++) begin
         if (c > 0 && wb_adr_i == temp_alarm_pkg::OFS_IDEAL) begin
            rd_val[(c-1)*temp_alarm_pkg::IDEAL_STRIDE +: IDW] = ideality_o[(c-1)*IDW +: IDW];
         end
         if (wb_adr_i == ch_adr(temp_alarm_pkg::OFS_HIGH, c)) rd_val[LW-1:0] = hi_lim[c];
         if (wb_adr_i == ch_adr(temp_alarm_pkg::OFS_LOW, c))  rd_val[LW-1:0] = lo_lim[c];
         if (wb_adr_i == ch_adr(temp_alarm_pkg::OFS_CRIT, c)) rd_val[LW-1:0] = cr_lim[c];
         if (wb_adr_i == ch_adr(temp_alarm_pkg::OFS_TEMP, c)) rd_val[TW-1:0] = temp[c];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg    <= temp_alarm_pkg::CFG_RST;
         consec <= temp_alarm_pkg::CONSEC_RST;
         hyst   <= temp_alarm_pkg::HYST_RST;
         chmask <= '0;
      end else if (wr_fire) begin
         case (wb_adr_i)
            temp_alarm_pkg::OFS_CFG:    cfg    <= merge8(cfg, wb_dat_i, wb_sel_i);
            temp_alarm_pkg::OFS_CONSEC: consec <= merge8(consec, wb_dat_i, wb_sel_i);
            temp_alarm_pkg::OFS_HYST:   hyst   <= merge8(hyst, wb_dat_i, wb_sel_i);
            temp_alarm_pkg::OFS_CHMASK: chmask <= NCH'(merge8(8'(chmask), wb_dat_i, wb_sel_i));
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int c = 0; c < NCH; c++) begin
            hi_lim[c] <= temp_alarm_pkg::HIGH_RST;
            lo_lim[c] <= temp_alarm_pkg::LOW_RST;
            cr_lim[c] <= temp_alarm_pkg::CRIT_RST;
         end
      end else if (wr_fire) begin
         for (int c = 0; c < NCH; c++) begin
            if (wb_adr_i == ch_adr(temp_alarm_pkg::OFS_HIGH, c)) hi_lim[c] <= merge8(hi_lim[c], wb_dat_i, wb_sel_i);
            if (wb_adr_i == ch_adr(temp_alarm_pkg::OFS_LOW, c))  lo_lim[c] <= merge8(lo_lim[c], wb_dat_i, wb_sel_i);
            if (wb_adr_i == ch_adr(temp_alarm_pkg::OFS_CRIT, c)) cr_lim[c] <= merge8(cr_lim[c], wb_dat_i, wb_sel_i);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ideality_o <= {(NCH-1){temp_alarm_pkg::IDEAL_RST}};
      end else if (wr_fire && wb_adr_i == temp_alarm_pkg::OFS_IDEAL) begin
         for (int c = 0; c < NCH-1; c++) begin
            if (wb_sel_i[c]) ideality_o[c*IDW +: IDW] <= wb_dat_i[c*temp_alarm_pkg::IDEAL_STRIDE +: IDW];
         end
      end
   end

   // beta enable reaches the first external front end only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         beta_comp_en_o <= 1'b0;
      end else begin
         beta_comp_en_o <= cfg[temp_alarm_pkg::CFG_BETA];
      end
   end

   temp_filter #(.W(TW)) i_temp_filter (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .load_i  (conv_take),
      .level_i (temp_alarm_pkg::filt_e'(cfg[temp_alarm_pkg::CFG_FILT +: 2])),
      .din_i   (raw_temp_i[TW +: TW]),
      .dout_o  (filt_y)
   );

   // a cathode ground short raises no fault flag, so nothing trips
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         eval  <= 1'b0;
         flt_q <= '0;
         for (int c = 0; c < NCH; c++) raw_q[c] <= '0;
      end else begin
         eval <= conv_take;
         if (conv_take) begin
            flt_q <= diode_fault_i & {{(NCH-1){1'b1}}, 1'b0};
            for (int c = 0; c < NCH; c++) raw_q[c] <= raw_temp_i[c*TW +: TW];
         end
      end
   end

   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         data[c] = (c == 1) ? filt_y : raw_q[c];
         // fault data reads zero, low check skipped
         if (flt_q[c]) data[c] = '0;
         v_hi[c] = !flt_q[c] && (comp ? (data[c][TW-1 -: LW] > hi_lim[c]) : (data[c][TW-1 -: LW] >= hi_lim[c]));
         // a shorted diode's zero reading falls under the low limit
         v_lo[c]      = !flt_q[c] && (data[c][TW-1 -: LW] < lo_lim[c]);
         // interrupt mode looks at high, low and fault
         viol_a[c]    = comp ? v_hi[c] : (v_hi[c] | v_lo[c] | flt_q[c]);
         viol_c[c]    = !flt_q[c] && (data[c][TW-1 -: LW] > cr_lim[c]);
         next_acnt[c] = viol_a[c] ? sat_inc(acnt[c], lim_a) : '0;
         next_ccnt[c] = viol_c[c] ? sat_inc(ccnt[c], lim_c) : '0;
         hit_a[c]     = viol_a[c] && next_acnt[c] == lim_a;
         hit_c[c]     = viol_c[c] && next_ccnt[c] == lim_c;
         act_a[c]     = !comp && acnt[c] == lim_a;
         below_h[c]   = data[c][TW-1 -: LW] < floor_sub(hi_lim[c], hyst);
         below_c[c]   = data[c][TW-1 -: LW] < floor_sub(cr_lim[c], hyst);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int c = 0; c < NCH; c++) begin
            acnt[c] <= '0;
            ccnt[c] <= '0;
            temp[c] <= '0;
         end
      end else if (eval) begin
         for (int c = 0; c < NCH; c++) begin
            acnt[c] <= next_acnt[c];
            ccnt[c] <= next_ccnt[c];
            temp[c] <= data[c];
         end
      end
   end

   // sticky status, hardware set wins over a clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_hi  <= '0;
         st_lo  <= '0;
         st_flt <= '0;
      end else begin
         st_hi  <= (st_hi & ~clr_w[temp_alarm_pkg::STAT_HI +: NCH]) | ((eval && !comp) ? (hit_a & v_hi) : '0);
         st_lo  <= (st_lo & ~clr_w[temp_alarm_pkg::STAT_LO +: NCH]) | ((eval && !comp) ? (hit_a & v_lo) : '0);
         st_flt <= (st_flt & ~clr_w[temp_alarm_pkg::STAT_FLT +: NCH]) | ((eval && !comp) ? (hit_a & flt_q) : '0);
      end
   end

   // comparator latch, released when all below high-hyst
   // its status bits drop with the output
   always_ff @(posedge clk_i) begin
      if (rst_i || !comp) begin
         cmp_st <= '0;
      end else if (eval) begin
         cmp_st <= (&below_h) ? '0 : (cmp_st | hit_a);
      end
   end

   // released only when every channel is below crit-hyst
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         crit_st <= '0;
      end else if (eval) begin
         crit_st <= (&below_c) ? '0 : (crit_st | hit_c);
      end
   end
   // open-drain: pin is pulled low while enable is high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         alert_o    <= 1'b0;
         alert_oe_o <= 1'b0;
      end else begin
         alert_o <= 1'b0;
         // global mask forces release in interrupt mode
         alert_oe_o <= comp ? |(cmp_st & ~chmask)
                            : (!cfg[temp_alarm_pkg::CFG_MASK] && |((st_hi | st_lo | st_flt | act_a) & ~chmask));
      end
   end

   // no mask reaches the critical output
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         therm_n_o <= 1'b1;
      end else begin
         therm_n_o <= ~|crit_st;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_crit_hit;
      eval && |hit_c;
   endsequence
   sequence s_therm_on;
      (|crit_st) ##1 !therm_n_o;
   endsequence
   sequence s_crit_release;
      (|crit_st) && eval && (&below_c);
   endsequence
   a_therm_set: assert property (s_crit_hit |=> s_therm_on)
      else $error("critical output not raised after hit");
   a_therm_hold: assert property ((|crit_st) && !(eval && &below_c) |=> (|crit_st))
      else $error("critical latch dropped early");
   a_crit_clear: assert property (s_crit_release |=> (crit_st == '0) ##1 therm_n_o)
      else $error("critical status not self cleared");
   a_therm_nomask: assert property ($rose(cfg[temp_alarm_pkg::CFG_MASK]) && (|crit_st) |=> !therm_n_o)
      else $error("mask affected critical output");
   a_int_alert: assert property (!comp && !cfg[temp_alarm_pkg::CFG_MASK] && |(st_hi & ~chmask) |=> alert_oe_o)
      else $error("interrupt alert not held by status");
   a_mask_off: assert property (!comp && cfg[temp_alarm_pkg::CFG_MASK] |=> !alert_oe_o)
      else $error("masked alert still driven");
   a_comp_mask: assert property (comp && |(cmp_st & ~chmask) |=> alert_oe_o)
      else $error("comparator alert blocked");
   a_cnt_clear: assert property (eval && !viol_a[0] |=> acnt[0] == '0)
      else $error("counter not cleared on clean reading");
   a_fault_zero: assert property (eval && flt_q[1] |=> temp[1] == '0 && st_lo[1] == $past(st_lo[1] & ~clr_w[temp_alarm_pkg::STAT_LO+1]))
      else $error("fault data not zero or low checked");
   a_standby: assert property (!eval |=> $stable(temp[0]) && $stable(crit_st))
      else $error("update without conversion");
endmodule : temp_limit_alarm

// ==== pkg/temp_alarm_pkg.sv ====
package temp_alarm_pkg;
   // data and field widths
   localparam int TW  = 11;
   localparam int LW  = 8;
   localparam int IDW = 6;
   localparam int CW  = 3;
   localparam int AW  = 8;

   // register byte offsets, one word each
   localparam logic [7:0] OFS_CFG    = 8'h00;
   localparam logic [7:0] OFS_CONSEC = 8'h04;
   localparam logic [7:0] OFS_HYST   = 8'h08;
   localparam logic [7:0] OFS_CHMASK = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_IDEAL  = 8'h14;
   localparam logic [7:0] OFS_HIGH   = 8'h20;
   localparam logic [7:0] OFS_LOW    = 8'h30;
   localparam logic [7:0] OFS_CRIT   = 8'h40;
   localparam logic [7:0] OFS_TEMP   = 8'h50;
   localparam int         CH_STRIDE  = 4;

   // configuration fields
   localparam int CFG_RUN  = 0;
   localparam int CFG_COMP = 1;
   localparam int CFG_MASK = 2;
   localparam int CFG_FILT = 3;
   localparam int CFG_BETA = 5;

   // consecutive count fields
   localparam int CON_ALERT = 0;
   localparam int CON_CRIT  = 3;

   // status word fields, four bits each
   localparam int STAT_HI   = 0;
   localparam int STAT_LO   = 4;
   localparam int STAT_FLT  = 8;
   localparam int STAT_CRIT = 12;

   localparam int IDEAL_STRIDE = 8;

   // reset values
   localparam logic [7:0]     CFG_RST    = 8'h01;
   localparam logic [7:0]     CONSEC_RST = 8'h00;
   localparam logic [7:0]     HYST_RST   = 8'h0A;
   localparam logic [7:0]     HIGH_RST   = 8'h55;
   localparam logic [7:0]     LOW_RST    = 8'h00;
   localparam logic [7:0]     CRIT_RST   = 8'h64;
   localparam logic [IDW-1:0] IDEAL_RST  = 6'h12;

   typedef enum logic [1:0] {
      FILT_OFF = 2'h0,
      FILT_L1  = 2'h1,
      FILT_L2  = 2'h2
   } filt_e;
endpackage : temp_alarm_pkg

// ==== tb/temp_limit_alarm_test.sv ====
`timescale 1ns/1ps
module temp_limit_alarm_test;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic        wb_we_i = 1'b0;
   logic [3:0]  wb_sel_i = 4'h0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o, conv_done_i, alert_o, alert_oe_o, therm_n_o, beta_comp_en_o, alert_line;
   logic [43:0] raw_temp_i;
   logic [3:0]  diode_fault_i;
   logic [17:0] ideality_o;
   int          fails = 0;
   int          samples_checked = 0;
   int          cycles = 0;

   always #5 clk_i = ~clk_i;

   temp_limit_alarm #(.NCH(4)) i_temp_limit_alarm (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_done_i(conv_done_i), .raw_temp_i(raw_temp_i),
      .diode_fault_i(diode_fault_i), .alert_o(alert_o), .alert_oe_o(alert_oe_o), .therm_n_o(therm_n_o),
      .beta_comp_en_o(beta_comp_en_o), .ideality_o(ideality_o));

   thermal_host_model #(.NCH(4)) i_thermal_host_model (.clk_i(clk_i), .alert_data_i(alert_o),
      .alert_oe_i(alert_oe_o), .therm_n_i(therm_n_o), .conv_done_o(conv_done_i), .raw_temp_o(raw_temp_i),
      .diode_fault_o(diode_fault_i), .alert_line_o(alert_line), .therm_line_o());

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict

   // a hang anywhere ends the run with a mismatch
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         print_verdict();
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel,
                      output logic [31:0] rd);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= sel;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : bus

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      logic [31:0] rd;
      bus(1'b1, adr, dat, 4'hF, rd);
   endtask : wr

   task automatic rchk(input string name, input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] rd;
      bus(1'b0, adr, 32'h0, 4'hF, rd);
      check(name, rd, exp);
   endtask : rchk

   // alert asserted means pin driven low; therm asserted means low
   task automatic pins(input string name, input logic a, input logic t);
      check(name, {29'h0, alert_oe_o, alert_line, ~therm_n_o}, {29'h0, a, ~a, t});
   endtask : pins

   task automatic cv(input logic [31:0] hbs, input logic [3:0] flt);
      i_thermal_host_model.convert(hbs, flt);
   endtask : cv

   task automatic settle;
      repeat (2) @(posedge clk_i);
      #1;
   endtask : settle

   task automatic t_reset;
      pins("reset pins", 1'b0, 1'b0);
      i_thermal_host_model.other_oe = 1'b1;
      #1;
      check("wired alert", {31'h0, alert_line}, 32'h0);
      i_thermal_host_model.other_oe = 1'b0;
      check("ideality", {14'h0, ideality_o}, {14'h0, {3{temp_alarm_pkg::IDEAL_RST}}});
      check("beta", {31'h0, beta_comp_en_o}, 32'h0);
      rchk("cfg", temp_alarm_pkg::OFS_CFG, {24'h0, temp_alarm_pkg::CFG_RST});
      rchk("hyst", temp_alarm_pkg::OFS_HYST, {24'h0, temp_alarm_pkg::HYST_RST});
      rchk("crit", temp_alarm_pkg::OFS_CRIT + 8'h0C, {24'h0, temp_alarm_pkg::CRIT_RST});
      rchk("unmapped", 8'h7C, 32'h0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_interrupt;
      cv(32'h28285428, 4'h0);
      pins("below high", 1'b0, 1'b0);
      cv(32'h28285528, 4'h0);
      pins("at high", 1'b1, 1'b0);
      rchk("status hi", temp_alarm_pkg::OFS_STATUS, 32'h2);
      rchk("temp ch1", temp_alarm_pkg::OFS_TEMP + 8'h04, 32'h2A8);
      cv(32'h28282828, 4'h0);
      pins("latched", 1'b1, 1'b0);
      wr(temp_alarm_pkg::OFS_STATUS, 32'h2);
      settle();
      pins("cleared", 1'b0, 1'b0);
      $display("test interrupt done");
   endtask : t_interrupt

   task automatic t_fault;
      wr(temp_alarm_pkg::OFS_LOW + 8'h08, 32'h10);
      wr(temp_alarm_pkg::OFS_CFG, 32'h05);
      cv(32'h28282828, 4'b0110);
      pins("masked fault", 1'b0, 1'b0);
      rchk("fault status", temp_alarm_pkg::OFS_STATUS, 32'h600);
      rchk("fault temp1", temp_alarm_pkg::OFS_TEMP + 8'h04, 32'h0);
      rchk("fault temp", temp_alarm_pkg::OFS_TEMP + 8'h08, 32'h0);
      wr(temp_alarm_pkg::OFS_CFG, 32'h01);
      settle();
      pins("unmasked", 1'b1, 1'b0);
      cv(32'h28282828, 4'h0);
      wr(temp_alarm_pkg::OFS_STATUS, 32'hFFF);
      cv(32'h28002828, 4'h0);
      pins("short", 1'b1, 1'b0);
      rchk("low status", temp_alarm_pkg::OFS_STATUS, 32'h40);
      cv(32'h28282828, 4'h0);
      wr(temp_alarm_pkg::OFS_STATUS, 32'hFFF);
      wr(temp_alarm_pkg::OFS_LOW + 8'h08, 32'h0);
      settle();
      pins("fault gone", 1'b0, 1'b0);
      $display("test fault done");
   endtask : t_fault

   task automatic t_critical;
      wr(temp_alarm_pkg::OFS_CONSEC, 32'h10);
      wr(temp_alarm_pkg::OFS_CFG, 32'h05);
      cv(32'h65282828, 4'h0);
      pins("crit once", 1'b0, 1'b0);
      cv(32'h28282828, 4'h0);
      cv(32'h65282828, 4'h0);
      pins("count reset", 1'b0, 1'b0);
      cv(32'h65282828, 4'h0);
      pins("crit twice", 1'b0, 1'b1);
      wr(temp_alarm_pkg::OFS_CFG, 32'h01);
      wr(temp_alarm_pkg::OFS_CFG, 32'h05);
      settle();
      pins("crit mask set", 1'b0, 1'b1);
      cv(32'h5A282828, 4'h0);
      pins("crit held", 1'b0, 1'b1);
      rchk("crit status", temp_alarm_pkg::OFS_STATUS, 32'h8008);
      rchk("crit reread", temp_alarm_pkg::OFS_STATUS, 32'h8008);
      cv(32'h59282828, 4'h0);
      pins("crit off", 1'b0, 1'b0);
      rchk("crit cleared", temp_alarm_pkg::OFS_STATUS, 32'h0008);
      cv(32'h28282828, 4'h0);
      wr(temp_alarm_pkg::OFS_STATUS, 32'hFFFF);
      wr(temp_alarm_pkg::OFS_CONSEC, 32'h0);
      wr(temp_alarm_pkg::OFS_CFG, 32'h01);
      $display("test critical done");
   endtask : t_critical

   task automatic t_comparator;
      wr(temp_alarm_pkg::OFS_CFG, 32'h03);
      cv(32'h28282855, 4'h0);
      pins("cmp at high", 1'b0, 1'b0);
      cv(32'h28282856, 4'h0);
      pins("cmp over", 1'b1, 1'b0);
      wr(temp_alarm_pkg::OFS_STATUS, 32'hF);
      rchk("cmp status", temp_alarm_pkg::OFS_STATUS, 32'h1);
      cv(32'h2828284B, 4'h0);
      pins("cmp held", 1'b1, 1'b0);
      cv(32'h2828284A, 4'h0);
      pins("cmp off", 1'b0, 1'b0);
      rchk("cmp cleared", temp_alarm_pkg::OFS_STATUS, 32'h0);
      wr(temp_alarm_pkg::OFS_CFG, 32'h07);
      cv(32'h28282856, 4'h0);
      pins("cmp gmask", 1'b1, 1'b0);
      cv(32'h2828284A, 4'h0);
      wr(temp_alarm_pkg::OFS_CHMASK, 32'h1);
      cv(32'h28282856, 4'h0);
      pins("cmp chmask", 1'b0, 1'b0);
      cv(32'h2828284A, 4'h0);
      wr(temp_alarm_pkg::OFS_CHMASK, 32'h0);
      wr(temp_alarm_pkg::OFS_CFG, 32'h00);
      cv(32'h70707070, 4'h0);
      pins("standby", 1'b0, 1'b0);
      rchk("standby temp", temp_alarm_pkg::OFS_TEMP, 32'h250);
      $display("test comparator done");
   endtask : t_comparator

   task automatic t_ideal;
      logic [31:0] rd;
      // ideality written while beta is off
      wr(temp_alarm_pkg::OFS_IDEAL, 32'h002A153F);
      bus(1'b1, temp_alarm_pkg::OFS_IDEAL, 32'h00010101, 4'h2, rd);
      #1;
      check("ideality", {14'h0, ideality_o}, {14'h0, 6'h2A, 6'h01, 6'h3F});
      rchk("ideal reg", temp_alarm_pkg::OFS_IDEAL, 32'h002A013F);
      wr(temp_alarm_pkg::OFS_CFG, 32'h21);
      settle();
      check("beta on", {31'h0, beta_comp_en_o}, 32'h1);
      $display("test ideality done");
   endtask : t_ideal

   task automatic t_filter;
      wr(temp_alarm_pkg::OFS_CFG, 32'h01);
      cv(32'h28282828, 4'h0);
      rchk("filter off", temp_alarm_pkg::OFS_TEMP + 8'h04, 32'h140);
      wr(temp_alarm_pkg::OFS_CFG, 32'h09);
      cv(32'h28283828, 4'h0);
      rchk("filter lvl1", temp_alarm_pkg::OFS_TEMP + 8'h04, 32'h180);
      wr(temp_alarm_pkg::OFS_CFG, 32'h11);
      cv(32'h28283828, 4'h0);
      rchk("filter lvl2", temp_alarm_pkg::OFS_TEMP + 8'h04, 32'h190);
      $display("test filter done");
   endtask : t_filter

   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      t_reset();
      t_interrupt();
      t_fault();
      t_critical();
      t_comparator();
      t_ideal();
      t_filter();
      print_verdict();
   end
endmodule : temp_limit_alarm_test

// ==== tb/thermal_host_model.sv ====
`timescale 1ns/1ps
module thermal_host_model #(
   parameter int NCH = 4
) (
   input  wire logic             clk_i,
   input  wire logic             alert_data_i,
   input  wire logic             alert_oe_i,
   input  wire logic             therm_n_i,
   output logic                  conv_done_o,
   output logic      [NCH*11-1:0] raw_temp_o,
   output logic      [NCH-1:0]    diode_fault_o,
   output logic                  alert_line_o,
   output logic                  therm_line_o
);
   logic other_oe = 1'b0;

   initial begin
      conv_done_o = 1'b0;
      raw_temp_o = '0;
      diode_fault_o = '0;
   end

   // shared open-drain wire
   // pull-up wins unless some source pulls low; a second alarm source may join
   assign alert_line_o = (alert_oe_i ? alert_data_i : 1'b1) & ~other_oe;
   assign therm_line_o = therm_n_i;

   // one conversion: pulse, then readings scrambled so only the captured copy counts
   task automatic convert(input logic [31:0] hbs, input logic [NCH-1:0] flt);
      @(posedge clk_i);
      for (int c = 0; c < NCH; c++) begin
         raw_temp_o[c*11+:11] <= {hbs[c*8+:8], 3'h0};
      end
      diode_fault_o <= flt;
      conv_done_o <= 1'b1;
      @(posedge clk_i);
      conv_done_o <= 1'b0;
      raw_temp_o <= ~raw_temp_o;
      diode_fault_o <= ~diode_fault_o;
      repeat (2) @(posedge clk_i);
      #1;
   endtask : convert
endmodule : thermal_host_model
